// ### common/bscan_pkg.sv
// constants, types and chain layout of the boundary scan test port
// ============================================================
package bscan_pkg;

    // ============================================================
    // port state machine, one-hot
    typedef enum logic [15:0] {
        ST_TEST_LOGIC_RESET = 16'h0001,
        ST_RUN_TEST_IDLE = 16'h0002,
        ST_SELECT_DR = 16'h0004,
        ST_CAPTURE_DR = 16'h0008,
        ST_SHIFT_DR = 16'h0010,
        ST_EXIT1_DR = 16'h0020,
        ST_PAUSE_DR = 16'h0040,
        ST_EXIT2_DR = 16'h0080,
        ST_UPDATE_DR = 16'h0100,
        ST_SELECT_IR = 16'h0200,
        ST_CAPTURE_IR = 16'h0400,
        ST_SHIFT_IR = 16'h0800,
        ST_EXIT1_IR = 16'h1000,
        ST_PAUSE_IR = 16'h2000,
        ST_EXIT2_IR = 16'h4000,
        ST_UPDATE_IR = 16'h8000
    } tap_state_e;

    // ============================================================
    // instruction register
    localparam int IR_WIDTH = 4;
    localparam logic [3:0] INSTR_EXTEST = 4'h0;
    localparam logic [3:0] INSTR_INTEST = 4'h1;
    localparam logic [3:0] INSTR_SAMPLE = 4'h2;
    localparam logic [3:0] INSTR_IDCODE = 4'h3;
    localparam logic [3:0] INSTR_CLAMP = 4'h4;
    localparam logic [3:0] INSTR_HIGHZ = 4'h5;
    localparam logic [3:0] INSTR_BYPASS = 4'hF;
    // fixed capture pattern, low two bits 01
    localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;

    // ============================================================
    // identification register; field values are arbitrary
    localparam int ID_WIDTH = 32;
    localparam logic [3:0] ID_VERSION = 4'h2;
    localparam logic [15:0] ID_DEVICE = 16'hA5C3;
    localparam logic [10:0] ID_MAKER = 11'h155;
    localparam logic [31:0] ID_VALUE = {ID_VERSION, ID_DEVICE, ID_MAKER, 1'b1};

    // ============================================================
    // boundary chain layout, index 0 is the position next to tdi
    localparam int PIN_COUNT = 50;
    localparam int CELLS_INPUT = 1;
    localparam int CELLS_BIDIR = 3;
    localparam logic [49:0] PIN_IS_BIDIR = 50'h0_017E_1DFF_7702;
    localparam int THROUGH_PIN_POS = 0;

    function automatic int cell_base(input int pos);
        int acc;
        acc = 0;
        for (int p = 0; p < pos; p++) begin
            acc += PIN_IS_BIDIR[p] ? CELLS_BIDIR : CELLS_INPUT;
        end
        return acc;
    endfunction : cell_base

    localparam int CELL_COUNT = cell_base(PIN_COUNT);

endpackage : bscan_pkg

// ### rtl/bscan_cell.sv
// one boundary cell: capture/shift stage and update latch
`timescale 1ns/1ps
module bscan_cell (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_capture,
    input wire logic i_shift,
    input wire logic i_update,
    input wire logic i_capture_val,
    input wire logic i_scan_in,
    output logic o_scan_out,
    output logic o_hold
);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_scan_out <= 1'b0;
        end else if (i_capture) begin
            o_scan_out <= i_capture_val;
        end else if (i_shift) begin
            o_scan_out <= i_scan_in;
        end
    end

    // update stage only moves on the update pulse, so clamp can hold it
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_hold <= 1'b0;
        end else if (i_update) begin
            o_hold <= o_scan_out;
        end
    end

endmodule : bscan_cell

// ### rtl/bscan_tap.sv
// boundary scan test port: state machine, instructions, chain and pin muxing
`timescale 1ns/1ps
module bscan_tap #(
    parameter int PINS = bscan_pkg::PIN_COUNT
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RST_B,
    input wire logic I_TCK,
    input wire logic I_TMS,
    input wire logic I_TDI,
    input wire logic I_TRST_B,
    output logic O_TDO,
    output logic O_TDO_OE,
    input wire logic [PINS-1:0] I_PIN_IN,
    output logic [PINS-1:0] O_PIN_OUT,
    output logic [PINS-1:0] O_PIN_OE,
    output logic [PINS-1:0] O_CORE_IN,
    input wire logic [PINS-1:0] I_CORE_OUT,
    input wire logic [PINS-1:0] I_CORE_OE
);

    // ============================================================
    // pin synchronisers
    logic tck_s1, tck_s2, tck_prev;
    logic tms_s1, tms_s2;
    logic tdi_s1, tdi_s2;
    logic trst_b_s1, trst_b_s2;
    logic [PINS-1:0] pin_s1, pin_s2;

    always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
        if (!I_RST_B) begin
            {tck_s1, tck_s2, tck_prev} <= 3'h0;
            {tms_s1, tms_s2, tdi_s1, tdi_s2} <= 4'hF;
            {trst_b_s1, trst_b_s2} <= 2'h0;
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            tck_s1 <= I_TCK;
            tck_s2 <= tck_s1;
            tck_prev <= tck_s2;
            tms_s1 <= I_TMS;
            tms_s2 <= tms_s1;
            tdi_s1 <= I_TDI;
            tdi_s2 <= tdi_s1;
            trst_b_s1 <= I_TRST_B;
            trst_b_s2 <= trst_b_s1;
            pin_s1 <= I_PIN_IN;
            pin_s2 <= pin_s1;
        end
    end

    // test clock edges, found by the system clock; tck up to 6.25 MHz leaves 16 samples per half period
    wire tck_rise = tck_s2 & ~tck_prev;
    wire tck_fall = ~tck_s2 & tck_prev;

    // ============================================================
    // state machine
    bscan_pkg::tap_state_e state;

    tap_fsm u_tap_fsm (
        .i_clk(I_CLK_SYS),
        .i_rst_b(I_RST_B),
        .i_trst_b(trst_b_s2),
        .i_tck_rise(tck_rise),
        .i_tms(tms_s2),
        .o_state(state)
    );

    wire in_reset = (state == bscan_pkg::ST_TEST_LOGIC_RESET);
    wire in_cap_ir = (state == bscan_pkg::ST_CAPTURE_IR);
    wire in_shift_ir = (state == bscan_pkg::ST_SHIFT_IR);
    wire in_upd_ir = (state == bscan_pkg::ST_UPDATE_IR);
    wire in_cap_dr = (state == bscan_pkg::ST_CAPTURE_DR);
    wire in_shift_dr = (state == bscan_pkg::ST_SHIFT_DR);
    wire in_upd_dr = (state == bscan_pkg::ST_UPDATE_DR);

    // ============================================================
    // instruction register
    logic [bscan_pkg::IR_WIDTH-1:0] ir_shift;
    logic [bscan_pkg::IR_WIDTH-1:0] ir;

    always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ir_shift <= bscan_pkg::IR_CAPTURE_VAL;
        end else if (tck_rise && in_cap_ir) begin
            ir_shift <= bscan_pkg::IR_CAPTURE_VAL;
        end else if (tck_rise && in_shift_ir) begin
            ir_shift <= {tdi_s2, ir_shift[bscan_pkg::IR_WIDTH-1:1]};
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ir <= bscan_pkg::INSTR_IDCODE;
        end else if (in_reset) begin
            ir <= bscan_pkg::INSTR_IDCODE;
        end else if (tck_fall && in_upd_ir) begin
            ir <= ir_shift;
        end
    end

    // ============================================================
    // instruction decode
    wire op_extest = (ir == bscan_pkg::INSTR_EXTEST);
    wire op_intest = (ir == bscan_pkg::INSTR_INTEST);
    wire op_sample = (ir == bscan_pkg::INSTR_SAMPLE);
    wire op_idcode = (ir == bscan_pkg::INSTR_IDCODE);
    wire op_clamp = (ir == bscan_pkg::INSTR_CLAMP);
    wire op_highz = (ir == bscan_pkg::INSTR_HIGHZ);
    wire sel_boundary = op_extest | op_intest | op_sample;
    wire sel_id = op_idcode;
    wire sel_bypass = ~sel_boundary & ~sel_id;

    wire dr_capture = tck_rise & in_cap_dr;
    wire dr_shift = tck_rise & in_shift_dr;
    wire dr_update = tck_fall & in_upd_dr;

    // ============================================================
    // bypass and identification registers
    logic bypass_bit;
    logic [bscan_pkg::ID_WIDTH-1:0] id_shift;

    always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
        if (!I_RST_B) begin
            bypass_bit <= 1'b0;
        end else if (dr_capture && sel_bypass) begin
            bypass_bit <= 1'b0;
        end else if (dr_shift && sel_bypass) begin
            bypass_bit <= tdi_s2;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
        if (!I_RST_B) begin
            id_shift <= bscan_pkg::ID_VALUE;
        end else if (dr_capture && sel_id) begin
            id_shift <= bscan_pkg::ID_VALUE;
        end else if (dr_shift && sel_id) begin
            id_shift <= {tdi_s2, id_shift[bscan_pkg::ID_WIDTH-1:1]};
        end
    end

    // ============================================================
    // boundary chain
    localparam int CELLS = bscan_pkg::CELL_COUNT;
    // nets: single bits are driven from many generate branches
    wire [CELLS:0] chain;
    wire [PINS-1:0] hold_in, hold_out, hold_oe;
    wire cell_capture = dr_capture & sel_boundary;
    wire cell_shift = dr_shift & sel_boundary;
    wire cell_update = dr_update & sel_boundary;

    assign chain[0] = tdi_s2;

    // only functional signal pins have cells
    // position zero, data_through_test_pin, sits next to tdi
    genvar gp;
    generate
        for (gp = 0; gp < PINS; gp++) begin : g_pin
            localparam int BASE = bscan_pkg::cell_base(gp);
            bscan_cell u_in (
                .i_clk(I_CLK_SYS),
                .i_rst_b(I_RST_B),
                .i_capture(cell_capture),
                .i_shift(cell_shift),
                .i_update(cell_update),
                .i_capture_val(pin_s2[gp]),
                .i_scan_in(chain[BASE]),
                .o_scan_out(chain[BASE+1]),
                .o_hold(hold_in[gp])
            );
            // bidir pins add output and enable cells
            if (bscan_pkg::PIN_IS_BIDIR[gp]) begin : g_bidir
                bscan_cell u_out (
                    .i_clk(I_CLK_SYS),
                    .i_rst_b(I_RST_B),
                    .i_capture(cell_capture),
                    .i_shift(cell_shift),
                    .i_update(cell_update),
                    .i_capture_val(I_CORE_OUT[gp]),
                    .i_scan_in(chain[BASE+1]),
                    .o_scan_out(chain[BASE+2]),
                    .o_hold(hold_out[gp])
                );
                bscan_cell u_oe (
                    .i_clk(I_CLK_SYS),
                    .i_rst_b(I_RST_B),
                    .i_capture(cell_capture),
                    .i_shift(cell_shift),
                    .i_update(cell_update),
                    .i_capture_val(I_CORE_OE[gp]),
                    .i_scan_in(chain[BASE+2]),
                    .o_scan_out(chain[BASE+3]),
                    .o_hold(hold_oe[gp])
                );
            end else begin : g_input
                // input-only pads never drive
                assign hold_out[gp] = 1'b0;
                assign hold_oe[gp] = 1'b0;
            end
        end
    endgenerate

    // ============================================================
    // pin and core muxing
    // update latch drives pads under external test
    // clamp drives the held values, which only move on update
    wire pins_from_cells = op_extest | op_clamp;
    // sample keeps the core path on the pads
    wire [PINS-1:0] next_pin_out = pins_from_cells ? hold_out : (I_CORE_OUT & bscan_pkg::PIN_IS_BIDIR);
    wire [PINS-1:0] next_pin_oe = op_highz ? '0 :
                                  pins_from_cells ? hold_oe : (I_CORE_OE & bscan_pkg::PIN_IS_BIDIR);
    // core inputs come from update latches under internal test
    wire [PINS-1:0] next_core_in = op_intest ? hold_in : pin_s2;

    always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_PIN_OUT <= '0;
            O_PIN_OE <= '0;
            O_CORE_IN <= '0;
        end else begin
            O_PIN_OUT <= next_pin_out;
            O_PIN_OE <= next_pin_oe;
            O_CORE_IN <= next_core_in;
        end
    end

    // ============================================================
    // test data out, changes on falling test clock edges
    wire dr_serial = sel_boundary ? chain[CELLS] : sel_id ? id_shift[0] : bypass_bit;
    wire next_tdo = in_shift_ir ? ir_shift[0] : dr_serial;

    always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_TDO <= 1'b0;
            O_TDO_OE <= 1'b0;
        end else if (!trst_b_s2) begin
            O_TDO_OE <= 1'b0;
        end else if (tck_fall) begin
            O_TDO <= next_tdo;
            O_TDO_OE <= in_shift_ir | in_shift_dr;
        end
    end

endmodule : bscan_tap

// ### rtl/tap_fsm.sv
// test access port state machine
`timescale 1ns/1ps
module tap_fsm (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_trst_b,
    input wire logic i_tck_rise,
    input wire logic i_tms,
    output bscan_pkg::tap_state_e o_state
);

    bscan_pkg::tap_state_e next_state;

    always_comb begin
        case (o_state)
            bscan_pkg::ST_TEST_LOGIC_RESET: next_state = i_tms ? bscan_pkg::ST_TEST_LOGIC_RESET
                                                                : bscan_pkg::ST_RUN_TEST_IDLE;
            bscan_pkg::ST_RUN_TEST_IDLE: next_state = i_tms ? bscan_pkg::ST_SELECT_DR : bscan_pkg::ST_RUN_TEST_IDLE;
            bscan_pkg::ST_SELECT_DR: next_state = i_tms ? bscan_pkg::ST_SELECT_IR : bscan_pkg::ST_CAPTURE_DR;
            bscan_pkg::ST_CAPTURE_DR: next_state = i_tms ? bscan_pkg::ST_EXIT1_DR : bscan_pkg::ST_SHIFT_DR;
            bscan_pkg::ST_SHIFT_DR: next_state = i_tms ? bscan_pkg::ST_EXIT1_DR : bscan_pkg::ST_SHIFT_DR;
            bscan_pkg::ST_EXIT1_DR: next_state = i_tms ? bscan_pkg::ST_UPDATE_DR : bscan_pkg::ST_PAUSE_DR;
            bscan_pkg::ST_PAUSE_DR: next_state = i_tms ? bscan_pkg::ST_EXIT2_DR : bscan_pkg::ST_PAUSE_DR;
            bscan_pkg::ST_EXIT2_DR: next_state = i_tms ? bscan_pkg::ST_UPDATE_DR : bscan_pkg::ST_SHIFT_DR;
            bscan_pkg::ST_UPDATE_DR: next_state = i_tms ? bscan_pkg::ST_SELECT_DR : bscan_pkg::ST_RUN_TEST_IDLE;
            bscan_pkg::ST_SELECT_IR: next_state = i_tms ? bscan_pkg::ST_TEST_LOGIC_RESET : bscan_pkg::ST_CAPTURE_IR;
            bscan_pkg::ST_CAPTURE_IR: next_state = i_tms ? bscan_pkg::ST_EXIT1_IR : bscan_pkg::ST_SHIFT_IR;
            bscan_pkg::ST_SHIFT_IR: next_state = i_tms ? bscan_pkg::ST_EXIT1_IR : bscan_pkg::ST_SHIFT_IR;
            bscan_pkg::ST_EXIT1_IR: next_state = i_tms ? bscan_pkg::ST_UPDATE_IR : bscan_pkg::ST_PAUSE_IR;
            bscan_pkg::ST_PAUSE_IR: next_state = i_tms ? bscan_pkg::ST_EXIT2_IR : bscan_pkg::ST_PAUSE_IR;
            bscan_pkg::ST_EXIT2_IR: next_state = i_tms ? bscan_pkg::ST_UPDATE_IR : bscan_pkg::ST_SHIFT_IR;
            bscan_pkg::ST_UPDATE_IR: next_state = i_tms ? bscan_pkg::ST_SELECT_DR : bscan_pkg::ST_RUN_TEST_IDLE;
            default: next_state = bscan_pkg::ST_TEST_LOGIC_RESET;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_state <= bscan_pkg::ST_TEST_LOGIC_RESET;
        // reset pin wins over any edge
        end else if (!i_trst_b) begin
            o_state <= bscan_pkg::ST_TEST_LOGIC_RESET;
        // mode select sampled at rising edge
        end else if (i_tck_rise) begin
            o_state <= next_state;
        end
    end

endmodule : tap_fsm

// ### tb/bscan_tap_chk.sv
// port-level assertions for the boundary scan test port
`timescale 1ns/1ps
module bscan_tap_chk #(
    parameter int PINS = 50
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RST_B,
    input wire logic I_TCK,
    input wire logic I_TRST_B,
    input wire logic O_TDO,
    input wire logic O_TDO_OE,
    input wire logic [PINS-1:0] I_PIN_IN,
    input wire logic [PINS-1:0] O_PIN_OUT,
    input wire logic [PINS-1:0] O_PIN_OE,
    input wire logic [PINS-1:0] O_CORE_IN,
    input wire logic [PINS-1:0] I_CORE_OUT,
    input wire logic [PINS-1:0] I_CORE_OE
);
    localparam logic [PINS-1:0] BIDIR = PINS'(bscan_pkg::PIN_IS_BIDIR);
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_RST_B);
    // ============================================================
    // sequences
    // long enough for the two-stage sync and the state register
    sequence trst_held;
        !I_TRST_B [*6];
    endsequence
    // no link clock fall still travelling through the sync
    sequence tck_quiet;
        !I_TCK [*7];
    endsequence
    sequence trst_free;
        I_TRST_B && $past(I_TRST_B, 8);
    endsequence
    // ============================================================
    // assertions
    a_trst_tdo_off:
        assert property (trst_held |-> !O_TDO_OE) else $error("tdo enabled in test reset");
    a_reset_outputs:
        assert property ($rose(I_RST_B) |-> !O_TDO_OE && O_PIN_OE == '0 && O_PIN_OUT == '0)
        else $error("outputs not cleared by reset");
    a_tdo_parked:
        assert property (tck_quiet ##0 trst_free |-> $stable(O_TDO)) else $error("tdo moved, clock parked");
    a_tdo_after_fall:
        assert property (!$stable(O_TDO) ##0 trst_free |-> !$past(I_TCK, 2)) else $error("tdo moved off a fall");
    a_oe_after_fall:
        assert property (!$stable(O_TDO_OE) ##0 trst_free |-> !$past(I_TCK, 2))
        else $error("tdo enable moved off a fall");
    a_inonly_quiet:
        assert property (((O_PIN_OE | O_PIN_OUT) & ~BIDIR) == '0) else $error("input-only pin driven");
    a_core_pass:
        assert property (trst_held ##0 ($stable(I_CORE_OUT) && $stable(I_CORE_OE)) [*3]
            |-> O_PIN_OUT == (I_CORE_OUT & BIDIR) && O_PIN_OE == (I_CORE_OE & BIDIR))
        else $error("pads do not follow core");
    a_pad_to_core:
        assert property (trst_held ##0 $stable(I_PIN_IN) [*5] |-> O_CORE_IN == I_PIN_IN)
        else $error("core does not see pads");
endmodule : bscan_tap_chk

bind bscan_tap bscan_tap_chk #(.PINS(PINS)) i_chk (
    .I_CLK_SYS(I_CLK_SYS), .I_RST_B(I_RST_B), .I_TCK(I_TCK), .I_TRST_B(I_TRST_B), .O_TDO(O_TDO),
    .O_TDO_OE(O_TDO_OE), .I_PIN_IN(I_PIN_IN), .O_PIN_OUT(O_PIN_OUT), .O_PIN_OE(O_PIN_OE),
    .O_CORE_IN(O_CORE_IN), .I_CORE_OUT(I_CORE_OUT), .I_CORE_OE(I_CORE_OE));

// ### tb/bscan_tap_tb.sv
// self-checking bench for the boundary scan test port
`timescale 1ns/1ps
module bscan_tap_tb;
    localparam int PINS = 50;
    localparam logic [49:0] BIDIR = bscan_pkg::PIN_IS_BIDIR;
    localparam logic [31:0] ID = {bscan_pkg::ID_VERSION, bscan_pkg::ID_DEVICE, bscan_pkg::ID_MAKER, 1'b1};
    localparam logic [49:0] P1 = 50'h1_5A5A_C3C3_0F0F;
    localparam logic [49:0] CO1 = 50'h3_FFFF_0000_FFFF;
    localparam logic [49:0] OE1 = 50'h2_AAAA_5555_AAAA;
    localparam logic [49:0] P2 = 50'h2_3456_789A_BCDE;
    localparam logic [49:0] CO2 = 50'h0_F0F0_F0F0_F0F0;
    localparam logic [49:0] OE2 = 50'h1_0FF0_0FF0_0FF0;
    localparam logic [49:0] VA = 50'h3_C3C3_3C3C_A5A5;
    localparam logic [49:0] VB = 50'h0_5555_AAAA_5555;
    localparam logic [49:0] VC = 50'h3_3333_CCCC_3333;
    logic clk, rst_b, tck, tms, tdi, trst_b, tdo, tdo_oe, tdo_w;
    logic [49:0] pin_in, pin_out, pin_oe, core_in, core_out, core_oe;
    logic [127:0] sout;
    int fails;
    int n_checks;
    // undriven tdo has no pull: show the inverse of the last level
    assign tdo_w = tdo_oe ? tdo : ~tdo;
    bscan_tap #(.PINS(PINS)) i_dut (
        .I_CLK_SYS(clk), .I_RST_B(rst_b), .I_TCK(tck), .I_TMS(tms), .I_TDI(tdi), .I_TRST_B(trst_b),
        .O_TDO(tdo), .O_TDO_OE(tdo_oe), .I_PIN_IN(pin_in), .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe),
        .O_CORE_IN(core_in), .I_CORE_OUT(core_out), .I_CORE_OE(core_oe));
    scan_tester i_tester (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_b(trst_b), .i_tdo(tdo_w));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ============================================================
    // helpers
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t ns: got %0h, expected %0h", $time, seen, exp);
        end
    endtask : check
    // stream image of the chain: bit i is i cells away from the tdo end
    function automatic logic [127:0] chain(input logic [49:0] a, input logic [49:0] b, input logic [49:0] c);
        logic [127:0] s;
        int k;
        s = '0;
        k = 101;
        for (int p = 0; p < 50; p++) begin
            s[k] = a[p];
            k--;
            if (BIDIR[p]) begin
                s[k] = b[p];
                s[k-1] = c[p];
                k -= 2;
            end
        end
        return s;
    endfunction : chain
    task automatic drive(input logic [49:0] a, input logic [49:0] b, input logic [49:0] c);
        @(posedge clk);
        #1;
        pin_in = a;
        core_out = b;
        core_oe = c;
        repeat (4) @(posedge clk);
        // keeps link edges clear of the system clock edge
        #1.3;
    endtask : drive
    task automatic load_ir(input logic [3:0] code);
        i_tester.scan(1'b1, 4, 128'(code), sout);
    endtask : load_ir
    // ============================================================
    // scenarios
    task automatic t_idcode();
        i_tester.pulse_reset();
        check(128'(tdo_oe), 128'h0);
        i_tester.scan(1'b0, 32, '1, sout);
        check(128'(sout[31:0]), 128'(ID));
        load_ir(bscan_pkg::INSTR_IDCODE);
        check(128'(sout[3:0]), 128'(bscan_pkg::IR_CAPTURE_VAL));
    endtask : t_idcode
    task automatic t_bypass();
        for (int c = 6; c < 16; c++) begin
            load_ir(4'(c));
            i_tester.scan(1'b0, 8, 128'hB4, sout);
            check(128'(sout[7:0]), 128'h68);
        end
        // live pad and core data while test reset is held
        drive(P2, CO2, OE2);
        i_tester.pulse_reset();
        i_tester.scan(1'b0, 32, '0, sout);
        check(128'(sout[31:0]), 128'(ID));
    endtask : t_bypass
    task automatic t_boundary();
        drive(P1, CO1, OE1);
        load_ir(bscan_pkg::INSTR_SAMPLE);
        i_tester.scan(1'b0, 102, chain(VA, VB, VC), sout);
        check(sout, chain(P1, CO1, OE1));
        check(128'(pin_out), 128'(CO1 & BIDIR));
        load_ir(bscan_pkg::INSTR_EXTEST);
        check(128'({pin_out, pin_oe}), 128'({VB & BIDIR, VC & BIDIR}));
        drive(P2, CO2, OE2);
        i_tester.scan(1'b0, 102, chain(~VA, ~VB, ~VC), sout);
        check(sout, chain(P2, CO2, OE2));
        check(128'({pin_out, pin_oe}), 128'({~VB & BIDIR, ~VC & BIDIR}));
        // core moves under clamp, pads must not
        load_ir(bscan_pkg::INSTR_CLAMP);
        drive(P1, CO1, OE1);
        i_tester.scan(1'b0, 8, 128'hB4, sout);
        check(128'(sout[7:0]), 128'h68);
        check(128'({pin_out, pin_oe}), 128'({~VB & BIDIR, ~VC & BIDIR}));
        load_ir(bscan_pkg::INSTR_HIGHZ);
        check(128'(pin_oe), 128'h0);
        load_ir(bscan_pkg::INSTR_INTEST);
        i_tester.scan(1'b0, 102, chain(VA, VB, VC), sout);
        check(sout, chain(P1, CO1, OE1));
        check(128'({core_in, pin_out}), 128'({VA, CO1 & BIDIR}));
    endtask : t_boundary
    // ============================================================
    // run control
    task automatic test_done();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    // whole run is about 34 us of link traffic
    initial begin
        #200000;
        fails++;
        $display("[ERR] %0t ns: run timed out", $time);
        test_done();
    end
    initial begin
        rst_b = 1'b0;
        pin_in = '0;
        core_out = '0;
        core_oe = '0;
        fails = 0;
        n_checks = 0;
        repeat (8) @(posedge clk);
        #1;
        rst_b = 1'b1;
        #1.3;
        t_idcode();
        t_bypass();
        t_boundary();
        test_done();
    end
endmodule : bscan_tap_tb

// ### tb/scan_tester.sv
// model of the external tester driving the test port link
`timescale 1ns/1ps
module scan_tester (
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    output logic o_trst_b,
    input wire logic i_tdo
);
    // 48 ns link period
    localparam int HALF_NS = 24;
    // released lines sit at their pull-up level, clock parked low
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
        o_trst_b = 1'b0;
    end
    // ============================================================
    // link cycles
    // one clock: data held across the rise, tdo read before the fall
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        o_tms = tms;
        o_tdi = tdi;
        #(HALF_NS);
        o_tck = 1'b1;
        #(HALF_NS);
        tdo = i_tdo;
        o_tck = 1'b0;
    endtask : tick
    task automatic walk(input logic [7:0] path, input int n);
        logic b;
        for (int i = 0; i < n; i++) begin
            tick(path[i], 1'b1, b);
        end
    endtask : walk
    // reset before any scan, then park in idle
    task automatic pulse_reset();
        o_trst_b = 1'b0;
        #60;
        o_trst_b = 1'b1;
        #40;
        walk(8'h00, 1);
    endtask : pulse_reset
    // idle to idle; lsb goes in and comes out first
    task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
        logic b;
        dout = '0;
        walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], b);
            dout[i] = b;
        end
        // tms left low, so idle holds; the next call drives it first
        walk(8'h01, 2);
    endtask : scan
endmodule : scan_tester
